// ### logic/cbtl_loopback.v
// Command/address bus training loopback with Avalon-MM register slave
`timescale 1ns/100ps
`include "cbtl_regs.vh"

// Contract
// - Nonzero field enters training, enables outputs
// - Training decodes only strobe-high commands
// - Strobe low means no command, inputs ignored
// - Capture after delay, drive outputs unclocked
// - Captured pattern out within 2tCK+10ns
// - Exit releases outputs within 1tCK+10ns
// - Two strobe-high cycles: capture, then exit/remap
// - Field 01 reflects rising-edge CA9..CA0
// - Field 10 reflects falling-edge CA9..CA0
// - Field 11 reflects inversion input and CA10
// - Inversion applies only when config one enables
// - Inversion enabled after reset
// - Byte mode one byte; word mode copies
// - Back-to-back training writes: keep first only (code keeps both: its filter spans one clock, and writes come two clocks apart)
// - Config two bit enters training self refresh
// - Self refresh ignores hibernate and supply-off
// - Exit ends self refresh; exit delay follows
// - Remap in self refresh stays in it
// - All no-operation encodings treated alike
// - Inversion low inverts pattern, high passes
module cbtl_loopback (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   // Avalon-MM slave
   input wire [`CBTL_ADDR_W-1:0] i_avs_address,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire [31:0] i_avs_writedata,
   input wire [3:0] i_avs_byteenable,
   output reg [31:0] o_avs_readdata,
   output wire o_avs_waitrequest,
   // Command/address pins
   input wire i_ck,
   input wire i_cke_n,
   input wire [10:0] i_ca,
   input wire i_ca_inversion_input_bar,
   // Reflected outputs, bit 0 channel A, bit 1 channel B
   output reg [15:0] o_dq,
   output reg [15:0] o_dq_alt,
   output reg [1:0] o_data_inversion_pin_bar,
   output reg [1:0] o_error_detect_pin,
   output reg o_out_oe,
   output reg o_alt_oe,
   // Mode state
   output reg o_training_self_refresh,
   output wire o_hibernate_en,
   output wire o_supply_off_en,
   output wire o_cmd_busy
);

   // ****************************************
   // Pin synchronisation
   // ****************************************
   wire [13:0] pins_sync;
   wire ck_s;
   wire cke_s;
   wire inv_bar_s;
   wire [10:0] ca_s;
   reg ck_d;

   cbtl_pin_sync #(
      .WIDTH(14)
   ) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin({i_ck, i_cke_n, i_ca_inversion_input_bar, i_ca}),
      .o_level(pins_sync)
   );

   assign ck_s = pins_sync[13];
   assign cke_s = pins_sync[12];
   assign inv_bar_s = pins_sync[11];
   assign ca_s = pins_sync[10:0];

   wire ck_rise = ck_s & ~ck_d;
   wire ck_fall = ~ck_s & ck_d;

   // ****************************************
   // Registers
   // ****************************************
   reg [1:0] train_field;
   reg inv_en;
   reg word_mode;
   reg hibernate;
   reg supply_off;
   reg srf_en;
   reg training;
   reg [1:0] active_map;
   reg [`CBTL_DLY_W-1:0] delay_cnt;
   reg prev_hi;
   reg capture_pend;
   reg train_wr_last;
   reg ack;
   reg [10:0] rise_ca;
   reg rise_inv;
   reg [10:0] fall_ca;
   reg fall_inv;

   // Delay loads; the counter takes the low bits on purpose
   localparam [31:0] mode_cyc = `CBTL_MODE_DLY_CYC;
   localparam [31:0] srex_cyc = `CBTL_SREX_CYC;

   wire access = i_avs_read | i_avs_write;
   wire bus_take = access & ack;
   wire train_sel = i_avs_address == `CBTL_OFS_TRAIN;
   wire train_wr = bus_take & i_avs_write & train_sel & i_avs_byteenable[0];
   wire [1:0] wr_field = i_avs_writedata[`CBTL_TRAIN_HI:`CBTL_TRAIN_LO];

   // One wait state: every access is answered on its second edge
   assign o_avs_waitrequest = access & ~ack;
   assign o_cmd_busy = delay_cnt != {`CBTL_DLY_W{1'b0}};
   // Self refresh masks both low-power settings
   assign o_hibernate_en = hibernate & ~o_training_self_refresh;
   assign o_supply_off_en = supply_off & ~o_training_self_refresh;

   always @(posedge i_clk) begin
      if (i_rst) begin
         ack <= 1'b0;
         o_avs_readdata <= 32'h00000000;
      end else begin
         ack <= access & ~ack;
         if (access & ~ack & i_avs_read) begin
            case (i_avs_address)
               `CBTL_OFS_TRAIN: o_avs_readdata <= {28'h0000000, train_field, 2'h0};
               `CBTL_OFS_CFG1: o_avs_readdata <= {21'h000000, inv_en, 10'h000};
               `CBTL_OFS_CFG2: begin
                  o_avs_readdata <= {21'h000000, srf_en, 7'h00, supply_off, hibernate,
                     word_mode};
               end
               `CBTL_OFS_STATUS: begin
                  o_avs_readdata <= {26'h0000000, active_map, o_cmd_busy, o_out_oe,
                     o_training_self_refresh, training};
               end
               `CBTL_OFS_CAPTURE: begin
                  o_avs_readdata <= {8'h00, fall_inv, fall_ca, rise_inv, rise_ca};
               end
               default: o_avs_readdata <= 32'h00000000;
            endcase
         end
      end
   end

   // ****************************************
   // Configuration writes
   // ****************************************
   always @(posedge i_clk) begin
      if (i_rst) begin
         inv_en <= `CBTL_RST_INV_EN;
         srf_en <= `CBTL_RST_SRF;
         word_mode <= 1'b0;
         hibernate <= 1'b0;
         supply_off <= 1'b0;
      end else if (bus_take & i_avs_write) begin
         if (i_avs_address == `CBTL_OFS_CFG1 && i_avs_byteenable[1]) begin
            inv_en <= i_avs_writedata[`CBTL_CFG1_INV_EN];
         end
         if (i_avs_address == `CBTL_OFS_CFG2) begin
            if (i_avs_byteenable[0]) begin
               word_mode <= i_avs_writedata[`CBTL_CFG2_WORD];
               hibernate <= i_avs_writedata[`CBTL_CFG2_HIBERNATE];
               supply_off <= i_avs_writedata[`CBTL_CFG2_SUPPLY_OFF];
            end
            if (i_avs_byteenable[1]) begin
               srf_en <= i_avs_writedata[`CBTL_CFG2_SRF];
            end
         end
      end
   end

   // ****************************************
   // Training control
   // ****************************************
   // Captures while the mode-change delay runs are dropped, but the cycle still counts as the first strobe-high one
   always @(posedge i_clk) begin
      if (i_rst) begin
         ck_d <= 1'b0;
         train_field <= `CBTL_MAP_OFF;
         train_wr_last <= 1'b0;
         training <= 1'b0;
         active_map <= `CBTL_MAP_OFF;
         o_training_self_refresh <= 1'b0;
         delay_cnt <= {`CBTL_DLY_W{1'b0}};
         prev_hi <= 1'b0;
         capture_pend <= 1'b0;
         rise_ca <= 11'h000;
         rise_inv <= 1'b1;
         fall_ca <= 11'h000;
         fall_inv <= 1'b1;
      end else begin
         ck_d <= ck_s;
         train_wr_last <= train_wr;
         if (o_cmd_busy) begin
            delay_cnt <= delay_cnt - 1'b1;
         end
         // A write in the very next clock cycle is discarded; a repeat in the next bus cycle is kept
         if (train_wr & ~train_wr_last) begin
            train_field <= wr_field;
            if (~training && wr_field != `CBTL_MAP_OFF) begin
               training <= 1'b1;
               active_map <= wr_field;
               o_training_self_refresh <= srf_en;
               delay_cnt <= mode_cyc[`CBTL_DLY_W-1:0];
            end
         end
         if (ck_rise & training) begin
            // Strobe low: no command whatever CA8 or the rest carry
            if (~cke_s) begin
               prev_hi <= 1'b0;
            end else if (prev_hi) begin
               prev_hi <= 1'b0;
               capture_pend <= 1'b0;
               if (train_field == `CBTL_MAP_OFF) begin
                  training <= 1'b0;
                  active_map <= `CBTL_MAP_OFF;
                  o_training_self_refresh <= 1'b0;
                  delay_cnt <= o_training_self_refresh ? srex_cyc[`CBTL_DLY_W-1:0] :
                     mode_cyc[`CBTL_DLY_W-1:0];
               end else begin
                  active_map <= train_field;
                  delay_cnt <= mode_cyc[`CBTL_DLY_W-1:0];
               end
            end else begin
               prev_hi <= 1'b1;
               if (~o_cmd_busy) begin
                  capture_pend <= 1'b1;
                  rise_ca <= ca_s;
                  rise_inv <= inv_bar_s;
               end
            end
         end
         if (ck_fall & capture_pend) begin
            fall_ca <= ca_s;
            fall_inv <= inv_bar_s;
            capture_pend <= 1'b0;
         end
      end
   end

   // ****************************************
   // Pattern to pins
   // ****************************************
   // Outputs follow the capture a few cycles after the falling half, well
   // inside the data-out limit; they are not aligned to any data clock
   reg [10:0] rise_eff;
   reg [10:0] fall_eff;
   reg [9:0] pattern;
   reg [7:0] byte_val;
   reg out_upd;

   always @* begin
      rise_eff = (inv_en & ~rise_inv) ? ~rise_ca : rise_ca;
      fall_eff = (inv_en & ~fall_inv) ? ~fall_ca : fall_ca;
      case (active_map)
         `CBTL_MAP_RISE: pattern = rise_eff[9:0];
         `CBTL_MAP_FALL: pattern = fall_eff[9:0];
         // Inversion disabled leaves the reflected inversion bit undefined; 0 here
         `CBTL_MAP_INV: begin
            pattern = {2'h0, inv_en & rise_inv, rise_eff[10], inv_en & fall_inv,
               fall_eff[10], 4'h0};
         end
         default: pattern = 10'h000;
      endcase
      byte_val = pattern[7:0];
   end

   always @(posedge i_clk) begin
      if (i_rst) begin
         out_upd <= 1'b0;
         o_dq <= 16'h0000;
         o_dq_alt <= 16'h0000;
         o_data_inversion_pin_bar <= 2'h3;
         o_error_detect_pin <= 2'h0;
         o_out_oe <= 1'b0;
         o_alt_oe <= 1'b0;
      end else begin
         out_upd <= ck_fall & capture_pend;
         o_out_oe <= training;
         o_alt_oe <= training & word_mode;
         // Spare bytes go quiet with their enable so no stale pattern is left
         if (~(training & word_mode)) begin
            o_dq_alt <= 16'h0000;
         end else if (out_upd) begin
            o_dq_alt <= {byte_val, byte_val};
         end
         if (out_upd) begin
            o_dq <= {byte_val, byte_val};
            if (active_map == `CBTL_MAP_INV) begin
               o_data_inversion_pin_bar <= 2'h3;
               o_error_detect_pin <= 2'h0;
            end else begin
               o_data_inversion_pin_bar <= {2{pattern[8]}};
               o_error_detect_pin <= {2{pattern[9]}};
            end
         end
      end
   end

endmodule

// ### logic/cbtl_regs.vh
// Register map, field positions, reset values and timing for the CA training loopback
`ifndef CBTL_REGS_VH
`define CBTL_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CBTL_ADDR_W 5
`define CBTL_OFS_TRAIN 5'h00
`define CBTL_OFS_CFG1 5'h04
`define CBTL_OFS_CFG2 5'h08
`define CBTL_OFS_STATUS 5'h0C
`define CBTL_OFS_CAPTURE 5'h10

// ****************************************
// Field positions
// ****************************************
`define CBTL_TRAIN_LO 2
`define CBTL_TRAIN_HI 3
`define CBTL_CFG1_INV_EN 10
`define CBTL_CFG2_WORD 0
`define CBTL_CFG2_HIBERNATE 1
`define CBTL_CFG2_SUPPLY_OFF 2
`define CBTL_CFG2_SRF 10
`define CBTL_ST_TRAINING 0
`define CBTL_ST_SRF 1
`define CBTL_ST_OUT_EN 2
`define CBTL_ST_BUSY 3
`define CBTL_ST_MAP_LO 4
`define CBTL_ST_MAP_HI 5

// ****************************************
// Field codes and reset values
// ****************************************
`define CBTL_MAP_OFF 2'h0
`define CBTL_MAP_RISE 2'h1
`define CBTL_MAP_FALL 2'h2
`define CBTL_MAP_INV 2'h3
`define CBTL_RST_INV_EN 1'h1
`define CBTL_RST_SRF 1'h0

// ****************************************
// Timing
// ****************************************
`define CBTL_CLK_NS 50
`define CBTL_TCK_NS 400
`define CBTL_REFLECT_MAX_NS (2 * `CBTL_TCK_NS + 10)
`define CBTL_RELEASE_MAX_NS (1 * `CBTL_TCK_NS + 10)
`define CBTL_REFLECT_MAX_CYC (`CBTL_REFLECT_MAX_NS / `CBTL_CLK_NS)
`define CBTL_RELEASE_MAX_CYC (`CBTL_RELEASE_MAX_NS / `CBTL_CLK_NS)
`define CBTL_MODE_DLY_NS 200
`define CBTL_SREX_NS 1000
`define CBTL_MODE_DLY_CYC ((`CBTL_MODE_DLY_NS + `CBTL_CLK_NS - 1) / `CBTL_CLK_NS)
`define CBTL_SREX_CYC ((`CBTL_SREX_NS + `CBTL_CLK_NS - 1) / `CBTL_CLK_NS)
`define CBTL_DLY_W 8

`endif

// ### logic/cbtl_pin_sync.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps

module cbtl_pin_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input wire i_clk,
   input wire i_rst,
   // Pin side
   input wire [WIDTH-1:0] i_pin,
   // Filtered level
   output reg [WIDTH-1:0] o_level
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   integer k;

   // ****************************************
   // Capture and agreement
   // ****************************************
   // Only stage2 reads stage1; a bit changes once stage2 and stage3 agree
   always @(posedge i_clk) begin
      if (i_rst) begin
         stage1 <= {WIDTH{1'b0}};
         stage2 <= {WIDTH{1'b0}};
         stage3 <= {WIDTH{1'b0}};
         o_level <= {WIDTH{1'b0}};
      end else begin
         stage1 <= i_pin;
         stage2 <= stage1;
         stage3 <= stage2;
         for (k = 0; k < WIDTH; k = k + 1) begin
            if (stage2[k] == stage3[k]) begin
               o_level[k] <= stage3[k];
            end
         end
      end
   end

endmodule

// ### test/cbtl_loopback_props.sv
// Assertion checker for the CA training loopback ports
`timescale 1ns/100ps
module cbtl_loopback_props (
   // Clock, reset and bus handshake
   input wire i_clk,
   input wire i_rst,
   input wire i_avs_read,
   input wire i_avs_write,
   input wire o_avs_waitrequest,
   // Link pins and reflected outputs
   input wire i_ck,
   input wire i_cke_n,
   input wire [15:0] o_dq,
   input wire [15:0] o_dq_alt,
   input wire [1:0] o_data_inversion_pin_bar,
   input wire o_out_oe,
   input wire o_alt_oe,
   input wire o_training_self_refresh,
   input wire o_hibernate_en,
   input wire o_supply_off_en
);
   // ****************************************
   // Ages since the raw link clock rose and since the strobe was high
   // ****************************************
   reg ck_q;
   reg [4:0] ck_age;
   reg [4:0] cke_age;
   always @(posedge i_clk) begin
      ck_q <= i_ck;
      if (i_rst || (i_ck && !ck_q)) begin
         ck_age <= 5'h00;
      end else if (ck_age != 5'h1F) begin
         ck_age <= ck_age + 5'h01;
      end
      if (i_rst || i_cke_n) begin
         cke_age <= 5'h00;
      end else if (cke_age != 5'h1F) begin
         cke_age <= cke_age + 5'h01;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // ****************************************
   // Properties
   // ****************************************
   alt_needs_out_a: assert property (o_alt_oe |-> o_out_oe)
      else $error("alt byte enable without main enable");
   alt_quiet_a: assert property (!o_alt_oe |-> o_dq_alt == 16'h0000)
      else $error("alt bytes driven while disabled");
   srf_in_train_a: assert property (o_training_self_refresh && $past(o_training_self_refresh)
      |-> o_out_oe)
      else $error("self refresh outside training");
   srf_masks_a: assert property (o_training_self_refresh |-> !o_hibernate_en && !o_supply_off_en)
      else $error("power mode passed through in self refresh");
   bus_one_wait_a: assert property ($rose(i_avs_read || i_avs_write)
      |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
      else $error("bus answer not after one wait");
   exit_time_a: assert property ($fell(o_out_oe) |-> ck_age <= 5'h08)
      else $error("drivers released late after exit");
   reflect_time_a: assert property (o_out_oe && $past(o_out_oe) && !$stable(o_dq)
      |-> ck_age <= 5'h10)
      else $error("reflection late after capture");
   strobe_gate_a: assert property (o_out_oe && $past(o_out_oe) && !$stable(o_dq)
      |-> cke_age <= 5'h0C)
      else $error("reflection changed without strobe");
   reset_vals_a: assert property ($past(i_rst) |-> !o_out_oe && o_data_inversion_pin_bar == 2'h3)
      else $error("outputs not at reset state");
endmodule
bind cbtl_loopback cbtl_loopback_props i_props (.i_clk(i_clk), .i_rst(i_rst),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
   .i_ck(i_ck), .i_cke_n(i_cke_n), .o_dq(o_dq), .o_dq_alt(o_dq_alt),
   .o_data_inversion_pin_bar(o_data_inversion_pin_bar), .o_out_oe(o_out_oe),
   .o_alt_oe(o_alt_oe), .o_training_self_refresh(o_training_self_refresh),
   .o_hibernate_en(o_hibernate_en), .o_supply_off_en(o_supply_off_en));

// ### test/cbtl_ca_drv.sv
// Behavioural controller driving the CA pins during training
`timescale 1ns/100ps
module cbtl_ca_drv (
   // Pins toward the device
   output logic o_ck,
   output logic o_cke_n,
   output logic [10:0] o_ca,
   output logic o_inv_bar
);
   initial begin
      o_ck = 1'b0;
      o_cke_n = 1'b0;
      o_ca = 11'h000;
      o_inv_bar = 1'b1;
   end
   // ****************************************
   // Link cycles; the clock stands still between frames
   // ****************************************
   task frame(input logic hi, input int n, input logic [10:0] rca, input logic rinv,
              input logic [10:0] fca, input logic finv);
      #17;
      repeat (n) begin
         o_cke_n = hi;
         o_ca = rca;
         o_inv_bar = rinv;
         #100 o_ck = 1'b1;
         #100 o_ca = fca;
         o_inv_bar = finv;
         #100 o_ck = 1'b0;
         #100;
      end
      // A strobe-low cycle closes the command and spaces the next capture
      o_cke_n = 1'b0;
      #100 o_ck = 1'b1;
      // Released lines show the inverse so a stale value cannot pass
      o_ca = ~fca;
      o_inv_bar = ~finv;
      #200 o_ck = 1'b0;
      #100;
   endtask
endmodule

// ### test/cbtl_loopback_test.sv
// Self-checking bench for the CA training loopback
`timescale 1ns/100ps
`include "cbtl_regs.vh"
module cbtl_loopback_test;
   logic i_clk, i_rst, i_avs_read, i_avs_write, o_avs_waitrequest;
   logic [`CBTL_ADDR_W-1:0] i_avs_address;
   logic [31:0] i_avs_writedata, o_avs_readdata, rd;
   logic [3:0] i_avs_byteenable;
   logic i_ck, i_cke_n, i_inv_bar, o_out_oe, o_alt_oe, o_srf, o_hib, o_soff, o_busy;
   logic [10:0] i_ca;
   logic [15:0] o_dq, o_dq_alt;
   logic [1:0] o_data_inv_bar, o_err_det;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;
   cbtl_loopback i_cbtl_loopback (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
      .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
      .o_avs_waitrequest(o_avs_waitrequest), .i_ck(i_ck), .i_cke_n(i_cke_n), .i_ca(i_ca),
      .i_ca_inversion_input_bar(i_inv_bar), .o_dq(o_dq), .o_dq_alt(o_dq_alt),
      .o_data_inversion_pin_bar(o_data_inv_bar), .o_error_detect_pin(o_err_det),
      .o_out_oe(o_out_oe),
      .o_alt_oe(o_alt_oe), .o_training_self_refresh(o_srf), .o_hibernate_en(o_hib),
      .o_supply_off_en(o_soff), .o_cmd_busy(o_busy));
   cbtl_ca_drv i_cbtl_ca_drv (.o_ck(i_ck), .o_cke_n(i_cke_n), .o_ca(i_ca), .o_inv_bar(i_inv_bar));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         bad_count = bad_count + 1;
         complete_run();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   task complete_run();
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares = compares + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task chk_refl(input logic [19:0] exp);
      chk("reflected pins", {12'h000, exp}, {12'h000, o_err_det, o_data_inv_bar, o_dq});
   endtask
   function logic [19:0] refl(input logic [9:0] p);
      return {{2{p[9]}}, {2{p[8]}}, {2{p[7:0]}}};
   endfunction
   task bus(input logic wr, input logic [`CBTL_ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= wr;
      i_avs_read <= !wr;
      // Waitrequest is looked at on rising edges only; the take edge ends the wait
      do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
      rd = o_avs_readdata;
      i_avs_write <= 1'b0;
      i_avs_read <= 1'b0;
   endtask
   task wait_ready();
      repeat (2) @(posedge i_clk);
      while (o_busy !== 1'b0) @(posedge i_clk);
   endtask
   task cap(input logic hi, input logic [10:0] rca, input logic ri, input logic [10:0] fca);
      i_cbtl_ca_drv.frame(hi, 1, rca, ri, fca, 1'b1);
      repeat (17) @(posedge i_clk);
   endtask
   task remap(input logic [31:0] code);
      bus(1'b1, `CBTL_OFS_TRAIN, code);
      i_cbtl_ca_drv.frame(1'b1, 2, 11'h000, 1'b1, 11'h000, 1'b1);
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      i_rst = 1'b1;
      i_avs_read = 1'b0;
      i_avs_write = 1'b0;
      i_avs_address = 5'h00;
      i_avs_writedata = 32'h0;
      i_avs_byteenable = 4'hF;
      repeat (8) @(posedge i_clk);
      i_rst <= 1'b0;
      bus(1'b0, `CBTL_OFS_CFG1, 32'h0);
      chk("inversion enable", 32'h1, {31'h0, rd[`CBTL_CFG1_INV_EN]});
      bus(1'b0, 5'h14, 32'h0);
      chk("unmapped read", 32'h0, rd);
      cap(1'b1, 11'h3FF, 1'b1, 11'h3FF);
      chk_refl(20'h30000);
      chk("drivers idle", 32'h0, {31'h0, o_out_oe});
      bus(1'b1, `CBTL_OFS_CFG2, 32'h407);
      bus(1'b1, `CBTL_OFS_TRAIN, 32'h4);
      wait_ready();
      chk("entry state", 32'h7, {29'h0, o_out_oe, o_alt_oe, o_srf});
      chk("masked modes", 32'h0, {30'h0, o_hib, o_soff});
      bus(1'b0, `CBTL_OFS_STATUS, 32'h0);
      chk("status", 32'h17, rd);
      cap(1'b0, 11'h2A5, 1'b1, 11'h2A5);
      chk_refl(20'h30000);
      cap(1'b1, 11'h2A5, 1'b1, 11'h155);
      chk_refl(refl(10'h2A5));
      chk("alt bytes", 32'hA5A5, {16'h0, o_dq_alt});
      bus(1'b0, `CBTL_OFS_CAPTURE, 32'h0);
      chk("capture word", 32'h00955AA5, rd);
      cap(1'b1, 11'h2A5, 1'b0, 11'h155);
      chk_refl(refl(10'h15A));
      bus(1'b1, `CBTL_OFS_CFG1, 32'h0);
      cap(1'b1, 11'h2A5, 1'b0, 11'h155);
      chk_refl(refl(10'h2A5));
      remap(32'h8);
      wait_ready();
      cap(1'b1, 11'h155, 1'b1, 11'h2CC);
      chk_refl(refl(10'h2CC));
      chk("self refresh kept", 32'h1, {31'h0, o_srf});
      bus(1'b1, `CBTL_OFS_CFG1, 32'h400);
      remap(32'hC);
      wait_ready();
      cap(1'b1, 11'h0FF, 1'b1, 11'h400);
      chk_refl(20'h3B0B0);
      remap(32'h0);
      repeat (3) @(posedge i_clk);
      chk("exit state", 32'h3, {28'h0, o_out_oe, o_srf, o_busy, o_hib});
      wait_ready();
      complete_run();
   end
endmodule
